// ==== core/scp_pkg.sv ====
// Purpose: Constants and types of the serial configuration port.
// Assumes: Registers are 16 bits wide and are written by 32-bit serial frames.
// Notes:   Summary of operation follows.
// Summary of operation
// - Serial writes are taken only while extended control mode is on.
// - Data is sampled on serial clock rising edges; no lowest clock rate.
// - A frame is 32 bits, MSB first: header, address, value.
// - Header is eleven zeros then a one, first zero sent first.
// - Then a 4-bit address MSB first, then 16 data bits.
// - A new frame starts right at the 33rd edge, no select toggle needed.
// - Register contents survive power-down entry and exit unchanged.
// - Nine registers decoded at 0,1,2,3,9,A,B,E,F; other addresses reserved.
// - Registers are write-only, reset to listed values, idle in normal mode.
// - Writing one to calibration bit 15 starts a calibration; bit reads back zero.
// - Config bit 13: one gives clock plus over-range, zero gives two clocks.
// - Config bit 12 enables the duty-cycle stabilizer; resets to one.
// - Config bit 11 sets 90 degree clock phase, double-rate only; resets zero.
// - Config bit 10 zero selects double-rate, one single-rate; resets zero.
// - Config bit 9 one gives standard amplitude, zero reduced; resets one.
// - Config bit 8 picks data edge (single-rate) or demux mode (double-rate).
// - Offset: bits 15:8 magnitude, bit 7 sign; reset zero, positive.
// - Gain: 9-bit code in bits 15:7, nominal and reset 1000 0000 0.
package scp_pkg;
    localparam int FRAME_BITS  = 32;
    localparam int HEADER_BITS = 12;
    localparam int ADDR_BITS   = 4;
    localparam int DATA_BITS   = 16;
    localparam logic [11:0] HEADER_PATTERN = 12'h001;

    // Register addresses
    localparam logic [3:0] ADDR_CAL       = 4'h0;
    localparam logic [3:0] ADDR_CFG       = 4'h1;
    localparam logic [3:0] ADDR_I_OFFSET  = 4'h2;
    localparam logic [3:0] ADDR_I_GAIN    = 4'h3;
    localparam logic [3:0] ADDR_EXT_CFG   = 4'h9;
    localparam logic [3:0] ADDR_Q_OFFSET  = 4'ha;
    localparam logic [3:0] ADDR_Q_GAIN    = 4'hb;
    localparam logic [3:0] ADDR_PH_FINE   = 4'he;
    localparam logic [3:0] ADDR_PH_COARSE = 4'hf;

    // Reset values
    localparam logic [15:0] RST_CAL       = 16'h7fff;
    localparam logic [15:0] RST_CFG       = 16'hb2ff;
    localparam logic [15:0] RST_OFFSET    = 16'h007f;
    localparam logic [15:0] RST_GAIN      = 16'h807f;
    localparam logic [15:0] RST_EXT_CFG   = 16'h03ff;
    localparam logic [15:0] RST_PH_FINE   = 16'h00ff;
    localparam logic [15:0] RST_PH_COARSE = 16'h007f;

    // Field positions
    localparam int BIT_CAL_START   = 15;
    localparam int BIT_SECOND_CLK  = 13;
    localparam int BIT_DUTY_STAB   = 12;
    localparam int BIT_DDR_PHASE   = 11;
    localparam int BIT_DDR_SEL_N   = 10;
    localparam int BIT_AMPLITUDE   = 9;
    localparam int BIT_EDGE_DEMUX  = 8;
    localparam int OFFSET_MAG_LSB  = 8;
    localparam int BIT_OFFSET_SIGN = 7;
    localparam int GAIN_LSB        = 7;

    // Pin positions inside the synchronised pin vector
    localparam int PIN_SCLK   = 0;
    localparam int PIN_SERIAL_INPUT_BIT  = 1;
    localparam int PIN_SEL_N  = 2;
    localparam int PIN_EXT    = 3;
    localparam int PIN_COUNT  = 4;

    typedef struct packed {
        logic [15:0] calibration_trigger;
        logic [15:0] output_configuration;
        logic [15:0] i_channel_offset;
        logic [15:0] i_channel_gain;
        logic [15:0] extended_configuration;
        logic [15:0] q_channel_offset;
        logic [15:0] q_channel_gain;
        logic [15:0] sample_phase_fine;
        logic [15:0] sample_phase_coarse;
    } scp_regs_s;

    typedef struct packed {
        logic       second_clock_select_n;
        logic       duty_stabilizer_on;
        logic       double_rate_clock_phase;
        logic       double_rate_select_n;
        logic       output_amplitude_select;
        logic       edge_and_demux_select;
        logic [7:0] i_offset_magnitude;
        logic       i_offset_negative;
        logic [8:0] i_gain_code;
        logic [7:0] q_offset_magnitude;
        logic       q_offset_negative;
        logic [8:0] q_gain_code;
    } scp_ctrl_s;

    typedef enum logic [1:0] {
        FRM_IDLE,
        FRM_SHIFT,
        FRM_DISCARD
    } scp_frame_e;
endpackage : scp_pkg

// ==== core/scp_pin_sync.sv ====
// Purpose: Three-stage synchroniser for pins from outside the clock domain.
// Assumes: Pins are plain levels; no reset value is needed beyond the chain's.
// Notes:   Only stages two and three leave this module; stage one feeds stage two alone.
`timescale 1ns/10ps
module scp_pin_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] pin_i,
    output logic      [WIDTH-1:0] stage_b_o,
    output logic      [WIDTH-1:0] stage_c_o
);
    // Whole chain in one struct
    typedef struct packed {
        logic [WIDTH-1:0] stage_a;
        logic [WIDTH-1:0] stage_b;
        logic [WIDTH-1:0] stage_c;
    } scp_sync_s;

    scp_sync_s st;
    scp_sync_s next_st;

    // Each stage takes the one before it; stage one feeds stage two alone
    always_comb begin
        next_st.stage_a = pin_i;
        next_st.stage_b = st.stage_a;
        next_st.stage_c = st.stage_b;
    end

    // Chain of three flops; reset parks every stage at zero
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Both outputs are flop stages
    assign stage_b_o = st.stage_b;
    assign stage_c_o = st.stage_c;
endmodule : scp_pin_sync

// ==== core/scp_serial_port.sv ====
// Purpose: Write-only three-wire configuration port and its register bank.
// Assumes: Serial clock runs far below clk_i so every level is seen by the filter.
// Notes:   Register outputs hold their values regardless of mode; settings_active_o
//          tells downstream logic whether to obey them or the normal-mode pins.
`timescale 1ns/10ps
module scp_serial_port (
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic              extended_mode_i,
    input  wire logic              serial_clock_i,
    input  wire logic              serial_input_bit_i,
    input  wire logic              serial_select_n_i,
    output scp_pkg::scp_regs_s     register_bank_o,
    output scp_pkg::scp_ctrl_s     control_o,
    output logic                   settings_active_o,
    output logic                   calibration_start_o,
    output logic                   frame_done_o,
    output logic                   frame_error_o
);
    // Whole state of the block in one struct
    typedef struct packed {
        logic [scp_pkg::PIN_COUNT-1:0]  pins;
        scp_pkg::scp_frame_e            frame;
        logic [4:0]                     bit_cnt;
        logic [31:0]                    shift;
        scp_pkg::scp_regs_s             regs;
        logic                           cal_start;
        logic                           done;
        logic                           error;
    } scp_state_s;

    localparam scp_pkg::scp_regs_s REGS_RESET = '{
        calibration_trigger:    scp_pkg::RST_CAL,
        output_configuration:   scp_pkg::RST_CFG,
        i_channel_offset:       scp_pkg::RST_OFFSET,
        i_channel_gain:         scp_pkg::RST_GAIN,
        extended_configuration: scp_pkg::RST_EXT_CFG,
        q_channel_offset:       scp_pkg::RST_OFFSET,
        q_channel_gain:         scp_pkg::RST_GAIN,
        sample_phase_fine:      scp_pkg::RST_PH_FINE,
        sample_phase_coarse:    scp_pkg::RST_PH_COARSE
    };

    // Select and extended mode rest in their inactive levels after reset
    localparam logic [scp_pkg::PIN_COUNT-1:0] PINS_RESET = 4'h4;

    localparam scp_state_s STATE_RESET = '{
        pins:      PINS_RESET,
        frame:     scp_pkg::FRM_IDLE,
        bit_cnt:   5'h00,
        shift:     32'h0000_0000,
        regs:      REGS_RESET,
        cal_start: 1'b0,
        done:      1'b0,
        error:     1'b0
    };

    localparam logic [4:0] LAST_BIT   = 5'(scp_pkg::FRAME_BITS - 1);
    localparam logic [4:0] HEADER_END = 5'(scp_pkg::HEADER_BITS - 1);

    scp_state_s                    st;
    scp_state_s                    next_st;
    logic [scp_pkg::PIN_COUNT-1:0] pin_raw;
    logic [scp_pkg::PIN_COUNT-1:0] pin_b;
    logic [scp_pkg::PIN_COUNT-1:0] pin_c;
    logic                          sclk_rise;
    logic                          taking;
    logic [31:0]                   shifted;

    // Store one frame's data into the addressed register; reserved addresses drop it
    function automatic scp_pkg::scp_regs_s apply_write(
        input scp_pkg::scp_regs_s regs,
        input logic [3:0]         addr,
        input logic [15:0]        data
    );
        scp_pkg::scp_regs_s r;
        r = regs;
        case (addr)
            scp_pkg::ADDR_CAL: begin
                // Start bit is an action, so it is not kept
                r.calibration_trigger = data;
                r.calibration_trigger[scp_pkg::BIT_CAL_START] = 1'b0;
            end
            scp_pkg::ADDR_CFG:       r.output_configuration   = data;
            scp_pkg::ADDR_I_OFFSET:  r.i_channel_offset       = data;
            scp_pkg::ADDR_I_GAIN:    r.i_channel_gain         = data;
            scp_pkg::ADDR_EXT_CFG:   r.extended_configuration = data;
            scp_pkg::ADDR_Q_OFFSET:  r.q_channel_offset       = data;
            scp_pkg::ADDR_Q_GAIN:    r.q_channel_gain         = data;
            scp_pkg::ADDR_PH_FINE:   r.sample_phase_fine      = data;
            scp_pkg::ADDR_PH_COARSE: r.sample_phase_coarse    = data;
            default:                 r = regs;
        endcase
        return r;
    endfunction : apply_write

    // Offset magnitude of an offset register
    function automatic logic [7:0] offset_mag(input logic [15:0] value);
        return value[scp_pkg::OFFSET_MAG_LSB +: 8];
    endfunction : offset_mag

    // Nine-bit gain code of a full-scale register
    function automatic logic [8:0] gain_code(input logic [15:0] value);
        return value[scp_pkg::GAIN_LSB +: 9];
    endfunction : gain_code

    assign pin_raw[scp_pkg::PIN_SCLK]  = serial_clock_i;
    assign pin_raw[scp_pkg::PIN_SERIAL_INPUT_BIT] = serial_input_bit_i;
    assign pin_raw[scp_pkg::PIN_SEL_N] = serial_select_n_i;
    assign pin_raw[scp_pkg::PIN_EXT]   = extended_mode_i;

    // All pins cross together so data keeps its alignment to the clock edge
    scp_pin_sync #(
        .WIDTH     (scp_pkg::PIN_COUNT)
    ) u_sync (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .pin_i     (pin_raw),
        .stage_b_o (pin_b),
        .stage_c_o (pin_c)
    );

    // Next-state logic: pin filter, frame tracker, register writes
    always_comb begin
        next_st           = st;
        next_st.cal_start = 1'b0;
        next_st.done      = 1'b0;
        next_st.error     = 1'b0;

        // A pin level is accepted once stages two and three agree
        next_st.pins = (st.pins & (pin_b ^ pin_c)) | (pin_c & ~(pin_b ^ pin_c));

        // Edge found on the filtered clock, any rate down to standstill
        sclk_rise = next_st.pins[scp_pkg::PIN_SCLK] & ~st.pins[scp_pkg::PIN_SCLK];
        shifted   = {st.shift[30:0], next_st.pins[scp_pkg::PIN_SERIAL_INPUT_BIT]};
        taking    = 1'b0;

        if (next_st.pins[scp_pkg::PIN_SEL_N] || !next_st.pins[scp_pkg::PIN_EXT]) begin
            // Idle port: counter held clear, nothing reaches the bank
            next_st.frame   = scp_pkg::FRM_IDLE;
            next_st.bit_cnt = 5'h00;
        end else begin
            case (st.frame)
                scp_pkg::FRM_IDLE,
                scp_pkg::FRM_SHIFT: begin
                    next_st.frame = scp_pkg::FRM_SHIFT;
                    taking        = sclk_rise;
                end
                scp_pkg::FRM_DISCARD: begin
                    // Count out the bad frame so the next one stays aligned
                    if (sclk_rise) begin
                        next_st.bit_cnt = st.bit_cnt + 5'h01;
                        if (st.bit_cnt == LAST_BIT) begin
                            next_st.bit_cnt = 5'h00;
                            next_st.frame   = scp_pkg::FRM_SHIFT;
                        end
                    end
                end
                default: begin
                    next_st.frame   = scp_pkg::FRM_IDLE;
                    next_st.bit_cnt = 5'h00;
                end
            endcase
        end

        if (taking) begin
            next_st.shift   = shifted;
            next_st.bit_cnt = st.bit_cnt + 5'h01;
            // Header checked as soon as its twelfth bit lands
            if (st.bit_cnt == HEADER_END && shifted[11:0] != scp_pkg::HEADER_PATTERN) begin
                next_st.frame = scp_pkg::FRM_DISCARD;
                next_st.error = 1'b1;
            end
            if (st.bit_cnt == LAST_BIT) begin
                // Counter wraps, so edge 33 opens the next frame
                next_st.bit_cnt = 5'h00;
                next_st.done    = 1'b1;
                // Address then data, each MSB first
                next_st.regs = apply_write(st.regs, shifted[19:16], shifted[15:0]);
                if (shifted[19:16] == scp_pkg::ADDR_CAL) begin
                    next_st.cal_start = shifted[scp_pkg::BIT_CAL_START];
                end
            end
        end
    end

    // Single state register; power-down has no path into it
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st <= STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    // Outputs are flop bits or plain slices of them
    assign register_bank_o     = st.regs;
    assign settings_active_o   = st.pins[scp_pkg::PIN_EXT];
    assign calibration_start_o = st.cal_start;
    assign frame_done_o        = st.done;
    assign frame_error_o       = st.error;

    // Decoded configuration fields
    assign control_o.second_clock_select_n =
        st.regs.output_configuration[scp_pkg::BIT_SECOND_CLK];
    assign control_o.duty_stabilizer_on =
        st.regs.output_configuration[scp_pkg::BIT_DUTY_STAB];
    assign control_o.double_rate_clock_phase =
        st.regs.output_configuration[scp_pkg::BIT_DDR_PHASE];
    assign control_o.double_rate_select_n =
        st.regs.output_configuration[scp_pkg::BIT_DDR_SEL_N];
    assign control_o.output_amplitude_select =
        st.regs.output_configuration[scp_pkg::BIT_AMPLITUDE];
    assign control_o.edge_and_demux_select =
        st.regs.output_configuration[scp_pkg::BIT_EDGE_DEMUX];

    // Per-channel offset and gain
    assign control_o.i_offset_magnitude = offset_mag(st.regs.i_channel_offset);
    assign control_o.i_offset_negative  =
        st.regs.i_channel_offset[scp_pkg::BIT_OFFSET_SIGN];
    assign control_o.i_gain_code        = gain_code(st.regs.i_channel_gain);
    assign control_o.q_offset_magnitude = offset_mag(st.regs.q_channel_offset);
    assign control_o.q_offset_negative  =
        st.regs.q_channel_offset[scp_pkg::BIT_OFFSET_SIGN];
    assign control_o.q_gain_code        = gain_code(st.regs.q_channel_gain);
endmodule : scp_serial_port

// ==== sim/scp_port_monitor.sv ====
// Purpose: Concurrent checks on the serial configuration port outputs.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes:   Bound to the port module; sees its ports only.
`timescale 1ns/10ps
module scp_port_monitor (
    input wire logic               clk_i,
    input wire logic               rst_n_i,
    input wire logic               extended_mode_i,
    input scp_pkg::scp_regs_s      register_bank_o,
    input scp_pkg::scp_ctrl_s      control_o,
    input wire logic               settings_active_o,
    input wire logic               calibration_start_o,
    input wire logic               frame_done_o,
    input wire logic               frame_error_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // A completion pulse is high for exactly one cycle
    sequence s_done_pulse;
        frame_done_o ##1 !frame_done_o;
    endsequence

    a_done_single: assert property (frame_done_o |-> s_done_pulse)
        else $error("frame done pulse longer than one cycle");
    a_cal_on_done: assert property (calibration_start_o |-> frame_done_o)
        else $error("calibration start without a finished frame");
    a_cal_bit_low: assert property (register_bank_o.calibration_trigger[15] == 1'b0)
        else $error("calibration start bit kept its one");
    a_bank_on_done: assert property ($changed(register_bank_o) |-> frame_done_o)
        else $error("register bank changed without a finished frame");
    a_done_active: assert property (frame_done_o |-> settings_active_o)
        else $error("frame accepted outside extended mode");
    a_no_overlap: assert property (!(frame_done_o && frame_error_o))
        else $error("done and error pulses together");
    a_mode_follow: assert property (extended_mode_i [*8] |=> settings_active_o)
        else $error("extended mode not taken up");
    a_reset_vals: assert property ($rose(rst_n_i) |->
        register_bank_o.output_configuration == 16'hb2ff && register_bank_o.i_channel_gain == 16'h807f)
        else $error("wrong value just after reset");
    a_cfg_fields: assert property (control_o[41:36] == register_bank_o.output_configuration[13:8])
        else $error("configuration fields differ from register");
    a_offset_fields: assert property (control_o[35:27] == register_bank_o.i_channel_offset[15:7])
        else $error("offset fields differ from register");
    a_gain_fields: assert property (control_o[26:18] == register_bank_o.i_channel_gain[15:7])
        else $error("gain code differs from register");
endmodule : scp_port_monitor

bind scp_serial_port scp_port_monitor u_port_monitor (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .extended_mode_i(extended_mode_i),
    .register_bank_o(register_bank_o), .control_o(control_o),
    .settings_active_o(settings_active_o), .calibration_start_o(calibration_start_o),
    .frame_done_o(frame_done_o), .frame_error_o(frame_error_o)
);

// ==== sim/scp_host_model.sv ====
// Purpose: Host controller model driving the three-wire configuration link.
// Assumes: Frames are whole unless a scenario cuts one short on purpose.
// Notes:   Serial clock stands low between frames; released data line flips.
`timescale 1ns/10ps
module scp_host_model (
    input  wire logic clk_i,
    output logic      serial_clock_o,
    output logic      serial_data_o,
    output logic      serial_select_n_o
);
    // Idle link
    initial begin
        serial_clock_o    = 1'b0;
        serial_data_o     = 1'b0;
        serial_select_n_o = 1'b1;
    end

    // Shift nbits of word MSB first; hold keeps select low for the next frame
    task automatic send(input logic [31:0] word, input int nbits, input bit hold,
                        input int half);
        @(posedge clk_i);
        #2;
        serial_select_n_o = 1'b0;
        for (int i = 31; i > 31 - nbits; i--) begin
            serial_data_o = word[i];
            #(half);
            serial_clock_o = 1'b1;
            #(half);
            serial_clock_o = 1'b0;
        end
        if (!hold) begin
            serial_select_n_o = 1'b1;
            serial_data_o     = ~serial_data_o;         // No stale bit once released
            #(2 * half);                                // Idle gap the filter can see
        end
    endtask : send
endmodule : scp_host_model

// ==== sim/tb_top.sv ====
// Purpose: Self-checking bench for the serial configuration port.
// Assumes: Host model runs a 400 ns serial clock unless told to go slower.
// Notes:   Expected bank is one 144-bit image in register order.
`timescale 1ns/10ps
module tb_top;
    logic               clk_i;
    logic               rst_n_i;
    logic               extended_mode_i;
    logic               sclk;
    logic               serial_input_bit;
    logic               sel_n;
    scp_pkg::scp_regs_s bank;
    scp_pkg::scp_ctrl_s ctrl;
    logic               active;
    logic               cal_start;
    logic               done;
    logic               err;
    logic [143:0]       exp_b;
    logic [143:0]       rst_b = {16'h7fff, 16'hb2ff, 16'h007f, 16'h807f, 16'h03ff,
                                 16'h007f, 16'h807f, 16'h00ff, 16'h007f};
    logic [3:0]         addrs [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h9, 4'ha, 4'hb, 4'he, 4'hf};
    logic [15:0]        wvals [9] = '{16'hffff, 16'h9eff, 16'ha5ff, 16'he07f, 16'h23ff,
                                      16'h5a7f, 16'h607f, 16'h80ff, 16'h8c7f};
    logic [3:0]         resv  [7] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hc, 4'hd};
    int                 fail_count;
    int                 checks;
    int                 n_done;
    int                 n_err;
    int                 n_cal;
    int                 cycles;
    // Assumed calibration length; the bench stays off the link meanwhile
    localparam int      CAL_CYCLES = 400;

    scp_serial_port uut (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .extended_mode_i(extended_mode_i),
        .serial_clock_i(sclk), .serial_input_bit_i(serial_input_bit), .serial_select_n_i(sel_n),
        .register_bank_o(bank), .control_o(ctrl), .settings_active_o(active),
        .calibration_start_o(cal_start), .frame_done_o(done), .frame_error_o(err)
    );
    scp_host_model u_host (.clk_i(clk_i), .serial_clock_o(sclk), .serial_data_o(serial_input_bit),
                           .serial_select_n_o(sel_n));

    // 20 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    // Pulse counters and hang guard
    always @(posedge clk_i) begin
        cycles++;
        n_done += int'(done === 1'b1);
        n_err  += int'(err === 1'b1);
        n_cal  += int'(cal_start === 1'b1);
        if (cycles == 20000) begin
            fail_count++;
            print_verdict();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // All nine registers against the expected image
    task automatic chk_bank();
        for (int i = 0; i < 9; i++) begin
            chk(bank[16*(8-i) +: 16], exp_b[16*(8-i) +: 16]);
        end
    endtask : chk_bank

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        u_host.send({12'h001, a, d}, 32, 1'b0, 200);
    endtask : wr

    task automatic at_edge();
        @(posedge clk_i);
        #2;
    endtask : at_edge

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict

    // Main sequence
    initial begin
        rst_n_i         = 1'b0;
        extended_mode_i = 1'b0;
        exp_b           = rst_b;
        repeat (2) @(posedge clk_i);
        #2;
        rst_n_i = 1'b1;
        repeat (8) @(posedge clk_i);
        chk_bank();
        wr(scp_pkg::ADDR_CFG, 16'h9eff);
        chk_bank();
        chk(16'(n_done), 16'h0000);
        at_edge();
        extended_mode_i = 1'b1;
        repeat (8) @(posedge clk_i);
        chk({15'h0000, active}, 16'h0001);
        // Each decoded register; start bit of calibration self-clears
        for (int i = 0; i < 9; i++) begin
            wr(addrs[i], wvals[i]);
            exp_b[16*(8-i) +: 16] = (i == 0) ? 16'h7fff : wvals[i];
            if (i == 0) begin
                // Let the calibration finish before the next write
                repeat (CAL_CYCLES) @(posedge clk_i);
            end
        end
        chk_bank();
        chk(16'(n_cal), 16'h0001);
        chk({10'h000, ctrl[41:36]}, 16'h001e);
        chk({7'h00, ctrl[35:27]}, 16'h014b);
        chk({7'h00, ctrl[26:18]}, 16'h01c0);
        chk({7'h00, ctrl[17:9]}, 16'h00b4);
        chk({7'h00, ctrl[8:0]}, 16'h00c0);
        foreach (resv[i]) wr(resv[i], 16'h1234);
        chk_bank();
        chk(16'(n_done), 16'h0010);
        // Wrong header, then a frame cut short by select
        u_host.send({12'h003, scp_pkg::ADDR_CFG, 16'h80ff}, 32, 1'b0, 200);
        chk(16'(n_err), 16'h0001);
        u_host.send({12'h001, scp_pkg::ADDR_I_GAIN, 16'h007f}, 20, 1'b0, 200);
        wr(scp_pkg::ADDR_I_OFFSET, 16'h00ff);
        exp_b[96 +: 16] = 16'h00ff;
        chk_bank();
        // Back to back with a slow serial clock, select held between frames
        u_host.send({12'h001, scp_pkg::ADDR_Q_GAIN, 16'h807f}, 32, 1'b1, 600);
        u_host.send({12'h001, scp_pkg::ADDR_PH_FINE, 16'h00ff}, 32, 1'b0, 600);
        exp_b[32 +: 16] = 16'h807f;
        exp_b[16 +: 16] = 16'h00ff;
        chk_bank();
        chk(16'(n_done), 16'h0013);
        // Leaving extended mode freezes the bank
        at_edge();
        extended_mode_i = 1'b0;
        repeat (8) @(posedge clk_i);
        wr(scp_pkg::ADDR_I_OFFSET, 16'h11ff);
        chk_bank();
        // Reset in mid-run restores every register
        at_edge();
        rst_n_i = 1'b0;
        repeat (4) @(posedge clk_i);
        #2;
        rst_n_i = 1'b1;
        exp_b   = rst_b;
        repeat (2) @(posedge clk_i);
        chk_bank();
        print_verdict();
    end
endmodule : tb_top
